// File: include/mcp_pkg.sv
// package of constants and types for the module control pin logic
// assumes one 250 MHz clock and a synchronous active-low reset
package mcp_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 250000;
  // longest time from laser-off request to transmitter dark, in ms
  localparam int unsigned TX_OFF_MAX_MS = 100;
  // longest time from request release to transmitter running, in ms
  localparam int unsigned TX_ON_MAX_MS = 100;
  // longest times as clock cycles, rounded down
  localparam int unsigned TX_OFF_MAX_CYC = TX_OFF_MAX_MS * CLK_KHZ;
  localparam int unsigned TX_ON_MAX_CYC = TX_ON_MAX_MS * CLK_KHZ;

  // ----------------------------------------------------------------
  // synchroniser and reset sequencing
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned PIN_COUNT = 3;
  localparam int unsigned PIN_DESELECT = 0;
  localparam int unsigned PIN_LASER_OFF = 1;
  localparam int unsigned PIN_POWER_DOWN = 2;
  localparam logic [PIN_COUNT-1:0] PIN_RESET_VAL = 3'h1; // deselected, laser on, powered up
  localparam int unsigned RST_CNT_W = 8;
  localparam logic [RST_CNT_W-1:0] RST_PULSE_CYC = 8'h10;
  localparam int unsigned COND_W = 8;
  localparam int unsigned INIT_CNT_W = 32;

  // ----------------------------------------------------------------
  // module life cycle
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MCP_ST_STANDBY,
    MCP_ST_RESET,
    MCP_ST_INIT,
    MCP_ST_READY
  } mcp_state_t;

endpackage : mcp_pkg

// File: logic/mcp_ctrl.sv
// low-speed control and status pin logic of a pluggable optical module
// assumes the host drives the control pins asynchronously, and that the
// management engine, monitors and receiver sit on i_clk inside the module
//
// Behaviour
// - answer management bus only while deselect low
// - laser off while laser-off request asserted
// - stay in standby while power-down high
// - power-down falling edge starts module reset
// - module-absent pin tied low
// - interrupt low while a condition needs service
// - provide receiver loss-of-signal status
// - not-ready high until module is ready
// - loss-of-signal 0 normal, 1 no signal
// - reset clears everything, management included
// - transmitter off within 100 ms
// - transmitter on within 100 ms
`timescale 1ns/1ps

module mcp_ctrl (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // host control pins, asynchronous
  input wire logic i_deselect_b,
  input wire logic i_laser_off_request,
  input wire logic i_power_down,
  // management engine, on i_clk
  input wire logic i_mgmt_sda_pull,
  input wire logic i_init_done,
  // monitors and receiver, on i_clk
  input wire logic [mcp_pkg::COND_W-1:0] i_condition,
  input wire logic i_signal_detect,
  // management data pin, open drain
  output logic o_sda_out,
  output logic o_sda_oe,
  // host status pins
  output logic o_interrupt_b,
  output logic o_module_absent,
  output logic o_module_unready,
  output logic o_receive_signal_lost,
  // internal controls
  output logic o_mgmt_enable,
  output logic o_laser_enable,
  output logic o_low_power,
  output logic o_module_reset_b
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------

  logic [mcp_pkg::PIN_COUNT-1:0] pin_raw;
  logic [mcp_pkg::PIN_COUNT-1:0] pin_sync;

  assign pin_raw[mcp_pkg::PIN_DESELECT] = i_deselect_b;
  assign pin_raw[mcp_pkg::PIN_LASER_OFF] = i_laser_off_request;
  assign pin_raw[mcp_pkg::PIN_POWER_DOWN] = i_power_down;

  // each host pin passes two flip-flops before use
  genvar gi;
  generate
    for (gi = 0; gi < mcp_pkg::PIN_COUNT; gi++)
    begin : g_sync
      mcp_sync #(
        .RESET_VAL(mcp_pkg::PIN_RESET_VAL[gi])
      ) u_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_pin(pin_raw[gi]),
        .o_level(pin_sync[gi])
      );
    end
  endgenerate

  logic deselected;
  logic laser_off;
  logic power_down;

  assign deselected = pin_sync[mcp_pkg::PIN_DESELECT];
  assign laser_off = pin_sync[mcp_pkg::PIN_LASER_OFF];
  assign power_down = pin_sync[mcp_pkg::PIN_POWER_DOWN];

  // ----------------------------------------------------------------
  // power-down edge detection
  // ----------------------------------------------------------------

  logic power_down_prev;
  logic power_down_fall;

  // previous value of the synchronised level, not of the first stage
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      power_down_prev <= 1'b0;
    end
    else
    begin
      power_down_prev <= power_down;
    end
  end

  assign power_down_fall = power_down_prev && !power_down;

  // ----------------------------------------------------------------
  // life cycle state machine
  // ----------------------------------------------------------------

  mcp_pkg::mcp_state_t state;
  mcp_pkg::mcp_state_t next_state;
  logic [mcp_pkg::RST_CNT_W-1:0] rst_cnt;
  logic rst_done;

  assign rst_done = (rst_cnt == mcp_pkg::RST_PULSE_CYC);

  // standby wins over everything; a falling edge restarts the reset
  always_comb
  begin
    next_state = state;
    if (power_down)
    begin
      next_state = mcp_pkg::MCP_ST_STANDBY;
    end
    else if (power_down_fall)
    begin
      next_state = mcp_pkg::MCP_ST_RESET;
    end
    else
    begin
      case (state)
        mcp_pkg::MCP_ST_STANDBY:
        begin
          next_state = mcp_pkg::MCP_ST_RESET;
        end
        mcp_pkg::MCP_ST_RESET:
        begin
          if (rst_done)
          begin
            next_state = mcp_pkg::MCP_ST_INIT;
          end
        end
        mcp_pkg::MCP_ST_INIT:
        begin
          if (i_init_done)
          begin
            next_state = mcp_pkg::MCP_ST_READY;
          end
        end
        default:
        begin
          next_state = mcp_pkg::MCP_ST_READY;
        end
      endcase
    end
  end

  // power-up behaves like a power-down release: a full reset first
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      state <= mcp_pkg::MCP_ST_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // reset pulse length counter, restarted on every entry to reset
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      rst_cnt <= '0;
    end
    else if (next_state != mcp_pkg::MCP_ST_RESET || state != mcp_pkg::MCP_ST_RESET)
    begin
      rst_cnt <= '0;
    end
    else if (!rst_done)
    begin
      rst_cnt <= rst_cnt + 1'b1;
    end
  end

  logic running;

  assign running = (state == mcp_pkg::MCP_ST_INIT) || (state == mcp_pkg::MCP_ST_READY);

  // ----------------------------------------------------------------
  // module-wide reset and power control
  // ----------------------------------------------------------------

  // held low through standby and the reset pulse, clearing all state
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      o_module_reset_b <= 1'b0;
      o_low_power <= 1'b0;
    end
    else
    begin
      o_module_reset_b <= (next_state == mcp_pkg::MCP_ST_INIT) ||
                          (next_state == mcp_pkg::MCP_ST_READY);
      o_low_power <= (next_state == mcp_pkg::MCP_ST_STANDBY);
    end
  end

  // ----------------------------------------------------------------
  // management bus gating
  // ----------------------------------------------------------------

  // the engine is enabled only when selected and out of reset
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      o_mgmt_enable <= 1'b0;
    end
    else
    begin
      o_mgmt_enable <= !deselected && running;
    end
  end

  // data pin only ever pulls low, and only while enabled
  assign o_sda_out = 1'b0;
  assign o_sda_oe = o_mgmt_enable && i_mgmt_sda_pull;

  // ----------------------------------------------------------------
  // laser transmitter control
  // ----------------------------------------------------------------

  // three cycles from pin to laser both ways, far inside both limits
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      o_laser_enable <= 1'b0;
    end
    else
    begin
      o_laser_enable <= !laser_off && running;
    end
  end

  // ----------------------------------------------------------------
  // status pins
  // ----------------------------------------------------------------

  // presence pin is grounded inside the module
  assign o_module_absent = 1'b0;

  // status outputs registered from the conditions, signal detect and the life cycle state
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      o_interrupt_b <= 1'b1;
      o_module_unready <= 1'b1;
      o_receive_signal_lost <= 1'b1;
    end
    else
    begin
      o_interrupt_b <= !(running && (|i_condition));
      o_module_unready <= (state != mcp_pkg::MCP_ST_READY);
      o_receive_signal_lost <= !(running && i_signal_detect);
    end
  end

endmodule : mcp_ctrl

// File: logic/mcp_sync.sv
// two flip-flop synchroniser for one asynchronous pin
// assumes the pin is a static level from outside the clock domain
`timescale 1ns/1ps

module mcp_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // pin side
  input wire logic i_pin,
  // synchronised level
  output logic o_level
);

  logic meta;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      meta <= RESET_VAL;
      o_level <= RESET_VAL;
    end
    else
    begin
      meta <= i_pin;
      o_level <= meta;
    end
  end

endmodule : mcp_sync

// File: verif/mcp_ctrl_chk.sv
// assertions on the ports of mcp_ctrl
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps

module mcp_ctrl_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // inputs watched
  input wire logic i_deselect_b,
  input wire logic i_laser_off_request,
  input wire logic i_power_down,
  input wire logic i_init_done,
  input wire logic [mcp_pkg::COND_W-1:0] i_condition,
  input wire logic i_signal_detect,
  // outputs watched
  input wire logic o_sda_oe,
  input wire logic o_interrupt_b,
  input wire logic o_module_absent,
  input wire logic o_module_unready,
  input wire logic o_receive_signal_lost,
  input wire logic o_mgmt_enable,
  input wire logic o_laser_enable,
  input wire logic o_low_power,
  input wire logic o_module_reset_b
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // ----------------------------------------------------------------
  // pin rules, allowing the synchroniser lag
  // ----------------------------------------------------------------
  a_absent_low:
    assert property (!o_module_absent) else $error("absent pin not low");
  a_desel_quiet:
    assert property (i_deselect_b [*4] |-> !o_mgmt_enable && !o_sda_oe) else $error("answers while deselected");
  a_mgmt_on:
    assert property ((!i_deselect_b && !i_power_down) [*6] ##0 !o_module_unready |-> o_mgmt_enable)
      else $error("management not enabled");
  a_laser_dark:
    assert property (i_laser_off_request [*4] |-> !o_laser_enable) else $error("laser on while off requested");
  a_laser_back:
    assert property ((!i_laser_off_request && !i_power_down) [*6] ##0 !o_module_unready |-> o_laser_enable)
      else $error("laser not resumed");
  a_standby_hold:
    assert property (i_power_down [*5] |-> o_low_power && !o_laser_enable && !o_mgmt_enable)
      else $error("standby not held");
  a_pd_reset:
    assert property ($fell(i_power_down) |-> ##3 (!o_low_power && !o_module_reset_b) [*8])
      else $error("no reset after power-down");
  a_intr_level:
    assert property (!o_module_unready && !i_power_down |=> o_interrupt_b == ($past(i_condition) == 8'h00))
      else $error("interrupt wrong");
  a_los_level:
    assert property (!o_module_unready && !i_power_down |=> o_receive_signal_lost == !$past(i_signal_detect))
      else $error("loss of signal wrong");
  a_unready_reset:
    assert property (!o_module_reset_b |=> o_module_unready) else $error("ready during reset");
  a_ready_gate:
    assert property ($fell(o_module_unready) |-> $past(i_init_done, 2)) else $error("ready without init");
  // main scenarios reached
  c_pd_fall: cover property ($fell(i_power_down));
  c_ready: cover property ($fell(o_module_unready));
  c_intr: cover property (!o_interrupt_b);
endmodule : mcp_ctrl_chk

bind mcp_ctrl mcp_ctrl_chk chk_u (
  .i_clk(i_clk),
  .i_rst_b(i_rst_b),
  .i_deselect_b(i_deselect_b),
  .i_laser_off_request(i_laser_off_request),
  .i_power_down(i_power_down),
  .i_init_done(i_init_done),
  .i_condition(i_condition),
  .i_signal_detect(i_signal_detect),
  .o_sda_oe(o_sda_oe),
  .o_interrupt_b(o_interrupt_b),
  .o_module_absent(o_module_absent),
  .o_module_unready(o_module_unready),
  .o_receive_signal_lost(o_receive_signal_lost),
  .o_mgmt_enable(o_mgmt_enable),
  .o_laser_enable(o_laser_enable),
  .o_low_power(o_low_power),
  .o_module_reset_b(o_module_reset_b)
);

// File: verif/mcp_ctrl_tb.sv
// self-checking bench of mcp_ctrl with the host pin model
// assumes mcp_pkg, the design, the host model and the checker compiled first
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("ERROR %s exp %0h got %0h", n, e, g); end end

module mcp_ctrl_tb;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_mgmt_sda_pull = 1'b0, i_init_done = 1'b0, i_signal_detect = 1'b0;
  logic [mcp_pkg::COND_W-1:0] i_condition = 8'h00;
  logic i_deselect_b, i_laser_off_request, i_power_down, o_sda_out, o_sda_oe, o_interrupt_b, o_module_absent;
  logic o_module_unready, o_receive_signal_lost, o_mgmt_enable, o_laser_enable, o_low_power, o_module_reset_b;
  int err_count = 0, n_tests = 0, cyc = 0;
  wire sda_line = o_sda_oe ? o_sda_out : 1'b1; // pulled up when released
  // ----------------------------------------------------------------
  // clock, design, host and hang guard
  // ----------------------------------------------------------------
  always #2 i_clk = ~i_clk;
  mcp_ctrl dut_u (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_deselect_b(i_deselect_b),
    .i_laser_off_request(i_laser_off_request),
    .i_power_down(i_power_down),
    .i_mgmt_sda_pull(i_mgmt_sda_pull),
    .i_init_done(i_init_done),
    .i_condition(i_condition),
    .i_signal_detect(i_signal_detect),
    .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe),
    .o_interrupt_b(o_interrupt_b),
    .o_module_absent(o_module_absent),
    .o_module_unready(o_module_unready),
    .o_receive_signal_lost(o_receive_signal_lost),
    .o_mgmt_enable(o_mgmt_enable),
    .o_laser_enable(o_laser_enable),
    .o_low_power(o_low_power),
    .o_module_reset_b(o_module_reset_b)
  );
  mcp_host host_u (.i_clk(i_clk), .o_deselect_b(i_deselect_b), .o_laser_off_request(i_laser_off_request),
    .o_power_down(i_power_down));
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      finish_test();
    end
  end

  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : wt

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  // bring-up: reset pulse, then ready once init is done
  task automatic t_bringup;
    `CHK("absent", 1'b0, o_module_absent)
    `CHK("los", 1'b1, o_receive_signal_lost)
    `CHK("reset", 1'b0, o_module_reset_b)
    `CHK("laser", 1'b0, o_laser_enable)
    wt(24);
    `CHK("reset", 1'b1, o_module_reset_b)
    `CHK("unready", 1'b1, o_module_unready)
    @(posedge i_clk);
    i_init_done <= 1'b1;
    wt(4);
    `CHK("ready", 1'b0, o_module_unready)
  endtask : t_bringup

  // select answers on the data line, deselect silences it
  task automatic t_select;
    host_u.pins(1'b0, 1'b0, 1'b0);
    i_mgmt_sda_pull <= 1'b1;
    wt(6);
    `CHK("sda", 1'b0, sda_line)
    host_u.pins(1'b1, 1'b0, 1'b0);
    wt(6);
    `CHK("sda", 1'b1, sda_line)
    `CHK("mgmt", 1'b0, o_mgmt_enable)
  endtask : t_select

  // laser off on request and back on release
  task automatic t_laser;
    host_u.pins(1'b1, 1'b1, 1'b0);
    wt(6);
    `CHK("laser", 1'b0, o_laser_enable)
    host_u.pins(1'b1, 1'b0, 1'b0);
    wt(6);
    `CHK("laser", 1'b1, o_laser_enable)
  endtask : t_laser

  // every condition bit raises the interrupt; signal detect drives los
  task automatic t_status;
    for (int k = 0; k < 8; k++)
    begin
      @(posedge i_clk);
      i_condition <= 8'h01 << k;
      wt(2);
      `CHK("intr", 1'b0, o_interrupt_b)
    end
    @(posedge i_clk);
    i_condition <= 8'h00;
    i_signal_detect <= 1'b1;
    wt(2);
    `CHK("intr", 1'b1, o_interrupt_b)
    `CHK("los", 1'b0, o_receive_signal_lost)
    @(posedge i_clk);
    i_signal_detect <= 1'b0;
    wt(2);
    `CHK("los", 1'b1, o_receive_signal_lost)
  endtask : t_status

  // standby while high, full reset on the falling edge
  task automatic t_power;
    host_u.pins(1'b0, 1'b0, 1'b1);
    wt(6);
    `CHK("lowpwr", 1'b1, o_low_power)
    host_u.pins(1'b0, 1'b0, 1'b0);
    wt(4);
    `CHK("reset", 1'b0, o_module_reset_b)
    `CHK("lowpwr", 1'b0, o_low_power)
    `CHK("mgmt", 1'b0, o_mgmt_enable)
    wt(30);
    `CHK("ready", 1'b0, o_module_unready)
    `CHK("mgmt", 1'b1, o_mgmt_enable)
  endtask : t_power

  initial
  begin
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    wt(1);
    t_bringup();
    t_select();
    t_laser();
    t_status();
    t_power();
    finish_test();
  end
endmodule : mcp_ctrl_tb

// File: verif/mcp_host.sv
// host board model driving the module control pins
// assumes the bench calls pins() from its main sequence
`timescale 1ns/1ps

module mcp_host (
  // clock
  input wire logic i_clk,
  // control pins towards the module
  output logic o_deselect_b,
  output logic o_laser_off_request,
  output logic o_power_down
);
  // idle host: module not addressed, laser allowed, powered up
  initial
  begin
    o_deselect_b = 1'b1;
    o_laser_off_request = 1'b0;
    o_power_down = 1'b0;
  end

  // pins change just after an edge and then stand as levels
  task automatic pins(input logic desel_b, input logic laser_off, input logic pd);
    @(posedge i_clk);
    o_deselect_b <= desel_b;
    o_laser_off_request <= laser_off;
    o_power_down <= pd;
  endtask : pins
endmodule : mcp_host
